// [rtl/rst_stat_pkg.sv]
// Purpose: Shared constants and types for the reset and link status block
// Assumes: 50 MHz aclk, AXI4-Lite word-aligned register access
// Notes:   Word offsets are register indices; byte address is four times
package rst_stat_pkg;

    // ****************************************
    // Register word offsets and groups
    // ****************************************
    localparam logic [11:0] PHY_LO_W     = 12'h300;
    localparam logic [11:0] PHY_HI_W     = 12'h3FF;
    localparam logic [11:0] TXMAC_LO_W   = 12'h400;
    localparam logic [11:0] TXMAC_HI_W   = 12'h4FF;
    localparam logic [11:0] RXMAC_LO_W   = 12'h500;
    localparam logic [11:0] RXMAC_HI_W   = 12'h5FF;
    localparam logic [11:0] FLOW_LO_W    = 12'h600;
    localparam logic [11:0] FLOW_HI_W    = 12'h708;
    localparam logic [11:0] STAT_LO_W    = 12'h800;
    localparam logic [11:0] STAT_HI_W    = 12'h9FF;
    localparam logic [11:0] TSTAMP_LO_W  = 12'hA00;
    localparam logic [11:0] TSTAMP_HI_W  = 12'hBFF;
    localparam logic [11:0] FEC_LO_W     = 12'hC00;
    localparam logic [11:0] FEC_HI_W     = 12'hDFF;

    localparam logic [11:0] REVISION_W   = 12'h300;
    localparam logic [11:0] SCRATCH_W    = 12'h301;
    localparam logic [11:0] STATUS_W     = 12'h3F0;
    localparam logic [11:0] CONTROL_W    = 12'h3F1;

    // Arbitrary neutral identification value
    localparam logic [31:0] REVISION_VAL = 32'h0000_0001;
    localparam logic [31:0] SCRATCH_RST  = 32'h0000_0000;
    localparam logic [1:0]  CONTROL_RST  = 2'h0;

    // Status flag indices, not the status word bit positions (tx_lanes_stable reads back at bit 7)
    localparam int ST_TX_STABLE  = 0;
    localparam int ST_BLOCK_LOCK = 1;
    localparam int ST_MARKER     = 2;
    localparam int ST_PCS_READY  = 3;
    localparam int ST_LOC_FAULT  = 4;
    localparam int ST_REM_FAULT  = 5;
    // Control bits: soft TX reset, soft RX reset
    localparam int CT_TX_SOFT    = 0;
    localparam int CT_RX_SOFT    = 1;

    // ****************************************
    // Timing counts
    // ****************************************
    localparam int BLOCK_LOCK_CYC = 64;
    localparam int LOCK_CNT_W     = 7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        GRP_NONE, GRP_PHY, GRP_MAC, GRP_FLOW, GRP_STAT, GRP_TSTAMP, GRP_FEC
    } reg_group_t;

    typedef struct packed {
        logic tx_lanes_stable;
        logic rx_block_lock;
        logic receive_marker_locked;
        logic rx_pcs_ready;
        logic local_fault_status;
        logic remote_fault_status;
        logic unidirectional_en;
        logic link_fault_gen_en;
    } status_t;

    typedef struct packed {
        logic tx_lanes_ok;
        logic sync_hdr_ok;
        logic marker_ok;
        logic local_fault;
        logic remote_fault;
    } phy_in_t;

endpackage

// [rtl/rst_sync.sv]
// Purpose: Two-stage reset synchroniser
// Assumes: Active-low reset in, from outside the aclk domain
// Notes:   Asserts at once, releases after two edges
`timescale 1ns/1ps
module rst_sync (
    input  wire logic aclk,
    input  wire logic rst_in_n,
    output logic      rst_out_n
);
    logic [1:0] stage_q;

    always_ff @(posedge aclk or negedge rst_in_n) begin
        if (!rst_in_n) begin
            stage_q <= 2'h0;
        end else begin
            stage_q <= {stage_q[0], 1'b1};
        end
    end

    assign rst_out_n = stage_q[1];
endmodule

// [rtl/eth_reset_status_ctrl.sv]
// Purpose: Reset sequencing, link status and register decode
// Assumes: aclk 50 MHz; AXI4-Lite slave, word-aligned 32-bit accesses
// Notes:   Status outputs all come from flip-flops
//
// Overview of operation
// [R1] Status outputs treated as asynchronous to client
// [R2] Lanes stable only when all lanes ready
// [R3] Block lock after 64 consecutive sync headers
// [R4] Marker lock with FEC, else follows lock
// [R5] PCS ready whenever block lock asserted
// [R6] Local fault status when fault generation present
// [R7] Remote fault status when fault generation present
// [R8] Unidirectional and fault-gen enables with clause support
// [R9] Three hard resets synchronised before use
// [R10] Host holds each reset ten cycles
// [R11] Both ready outputs signal reset complete
// [R12] Global reset clears registers and readies
// [R13] TX reset drops lanes stable
// [R14] RX reset drops PCS ready
// [R15] Host asserts channel reset before speed change
// [R16] Word addressed, full 32-bit accesses only
// [R17] Writes to read-only fields ignored
// [R18] Writes to reserved registers discarded
// [R19] Word offsets decode into register groups
// [R20] Host avoids undefined bits and registers
// [R21] Host disables calibration before reconfig access
// [R22] PHY registers reset only by global reset
// [R23] Two-stage synchroniser per reset input
// [R24] Status low while affecting reset asserted
`timescale 1ns/1ps
module eth_reset_status_ctrl
    import rst_stat_pkg::*;
#(
    parameter bit FEC_EN        = 1'b0,
    parameter bit FAULT_GEN_EN  = 1'b1,
    parameter bit UNIDIR_CLAUSE = 1'b1
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 tx_rst_n,
    input  wire logic                 rx_rst_n,
    input  wire logic                 csr_rst_n,
    input  wire logic                 channel_reset,
    input  wire rst_stat_pkg::phy_in_t phy_in,
    output rst_stat_pkg::status_t     status,
    input  wire logic [13:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [13:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);
    import rst_stat_pkg::*;

    // ****************************************
    // Decode function
    // ****************************************
    function automatic reg_group_t group_of(input logic [11:0] w);
        if (w >= PHY_LO_W && w <= PHY_HI_W) return GRP_PHY;       // R19
        if (w >= TXMAC_LO_W && w <= RXMAC_HI_W) return GRP_MAC;   // R19
        if (w >= FLOW_LO_W && w <= FLOW_HI_W) return GRP_FLOW;    // R19
        if (w >= STAT_LO_W && w <= STAT_HI_W) return GRP_STAT;    // R19
        if (w >= TSTAMP_LO_W && w <= TSTAMP_HI_W) return GRP_TSTAMP;
        if (w >= FEC_LO_W && w <= FEC_HI_W) return GRP_FEC;       // R19
        return GRP_NONE;
    endfunction

    // ****************************************
    // Reset synchronisers
    // ****************************************
    logic [2:0] rst_raw_n;
    logic [2:0] rst_syn_n;

    assign rst_raw_n = {csr_rst_n & aresetn,
                        rx_rst_n & csr_rst_n & aresetn,
                        tx_rst_n & csr_rst_n & aresetn};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            rst_sync u_sync (                                     // R9 R23
                .aclk      (aclk),
                .rst_in_n  (rst_raw_n[gi]),
                .rst_out_n (rst_syn_n[gi])
            );
        end
    endgenerate

    logic csr_ok;
    logic tx_ok;
    logic rx_ok;
    logic chan_q1;
    logic chan_q2;
    logic ctl_tx_soft;
    logic ctl_rx_soft;

    assign csr_ok = rst_syn_n[2];
    assign tx_ok  = rst_syn_n[0] & ~chan_q2 & ~ctl_tx_soft;      // R13
    assign rx_ok  = rst_syn_n[1] & ~chan_q2 & ~ctl_rx_soft;      // R14

    // ****************************************
    // Input synchronisers for link status and channel reset
    // ****************************************
    phy_in_t phy_s1_q;
    phy_in_t phy_s2_q;

    always_ff @(posedge aclk) begin
        phy_s1_q <= phy_in;                                       // R1
        phy_s2_q <= phy_s1_q;
        chan_q1  <= channel_reset;                                // R15
        chan_q2  <= chan_q1;
    end

    // ****************************************
    // Lock counter and status
    // ****************************************
    logic [LOCK_CNT_W-1:0] lock_cnt_q;
    logic [LOCK_CNT_W-1:0] lock_cnt_d;
    status_t               stat_q;
    status_t               stat_d;
    logic                  lock_now;

    localparam logic [LOCK_CNT_W-1:0] LOCK_LAST =
        LOCK_CNT_W'(BLOCK_LOCK_CYC);

    always_comb begin
        lock_cnt_d = lock_cnt_q;
        if (!rx_ok || !phy_s2_q.sync_hdr_ok) begin
            lock_cnt_d = '0;                                      // R3
        end else if (lock_cnt_q != LOCK_LAST) begin
            lock_cnt_d = lock_cnt_q + 1'b1;
        end
        lock_now = rx_ok && (lock_cnt_q == LOCK_LAST);            // R3

        stat_d = '0;                                              // R24
        stat_d.tx_lanes_stable = tx_ok && phy_s2_q.tx_lanes_ok;   // R2 R11
        stat_d.rx_block_lock   = lock_now;
        stat_d.rx_pcs_ready    = lock_now;                        // R5 R11
        stat_d.receive_marker_locked =
            FEC_EN ? (lock_now && phy_s2_q.marker_ok) : lock_now; // R4
        if (FAULT_GEN_EN) begin
            stat_d.local_fault_status  = rx_ok && phy_s2_q.local_fault;
            stat_d.remote_fault_status = rx_ok && phy_s2_q.remote_fault;
            stat_d.unidirectional_en   = csr_ok && UNIDIR_CLAUSE;    // R8
            stat_d.link_fault_gen_en   = csr_ok && UNIDIR_CLAUSE;    // R8
        end                                                       // R6 R7
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !csr_ok) begin                            // R12
            lock_cnt_q <= '0;
            stat_q     <= '0;
        end else begin
            lock_cnt_q <= lock_cnt_d;
            stat_q     <= stat_d;
        end
    end

    assign status = stat_q;

    // ****************************************
    // AXI4-Lite slave and PHY registers
    // ****************************************
    logic        aw_held_q, aw_held_d;
    logic [11:0] aw_word_q, aw_word_d;
    logic        w_held_q, w_held_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0]  w_strb_q, w_strb_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [31:0] scratch_q, scratch_d;
    logic [1:0]  ctrl_q, ctrl_d;
    logic        do_write;
    logic [11:0] ar_word;
    logic        awready_q;
    logic        wready_q;
    logic        arready_q;

    assign ctl_tx_soft = ctrl_q[CT_TX_SOFT];
    assign ctl_rx_soft = ctrl_q[CT_RX_SOFT];
    assign ar_word     = s_axi_araddr[13:2];                      // R16

    always_comb begin
        aw_held_d = aw_held_q;
        aw_word_d = aw_word_q;
        w_held_d  = w_held_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        scratch_d = scratch_q;
        ctrl_d    = ctrl_q;

        if (s_axi_awvalid && !aw_held_q && !bvalid_q) begin
            aw_held_d = 1'b1;
            aw_word_d = s_axi_awaddr[13:2];                       // R16
        end
        if (s_axi_wvalid && !w_held_q && !bvalid_q) begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end

        do_write = aw_held_q && w_held_q && !bvalid_q;
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            if (w_strb_q != 4'hF) begin
                bresp_d = RESP_SLVERR;                            // R16
            end else if (aw_word_q == SCRATCH_W) begin
                scratch_d = w_data_q;
            end else if (aw_word_q == CONTROL_W) begin
                ctrl_d = w_data_q[1:0];
            end else if (group_of(aw_word_q) == GRP_NONE) begin
                bresp_d = RESP_SLVERR;                            // R18
            end                                                   // R17
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end

        // Answer only after the address handshake
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            unique case (ar_word)
                REVISION_W: rdata_d = REVISION_VAL;
                SCRATCH_W:  rdata_d = scratch_q;
                CONTROL_W:  rdata_d = {30'h0, ctrl_q};
                STATUS_W:   rdata_d = {24'h0, stat_q};
                default: begin
                    if (group_of(ar_word) == GRP_NONE) begin
                        rresp_d = RESP_SLVERR;                    // R18
                    end
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_word_q <= '0;
            w_held_q  <= 1'b0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            aw_word_q <= aw_word_d;
            w_held_q  <= w_held_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // PHY registers see only the global reset
    always_ff @(posedge aclk) begin
        if (!aresetn || !csr_ok) begin                            // R22 R12
            scratch_q <= SCRATCH_RST;
            ctrl_q    <= CONTROL_RST;
        end else begin
            scratch_q <= scratch_d;
            ctrl_q    <= ctrl_d;
        end
    end

    // Ready flags registered from held state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
            if (s_axi_awvalid && !aw_held_q && !bvalid_q && !awready_q)
                awready_q <= 1'b1;
            if (s_axi_wvalid && !w_held_q && !bvalid_q && !wready_q)
                wready_q <= 1'b1;
            if (s_axi_arvalid && !rvalid_q && !arready_q)
                arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_arready = arready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

endmodule

// [sim/eth_reset_status_ctrl_assertions.sv]
// Purpose: Port-level checks on the reset and status block
// Assumes: One aclk domain, aresetn synchronous active low
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module eth_reset_status_ctrl_assertions
    import rst_stat_pkg::*;
#(
    parameter bit FEC_EN = 1'b0
) (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  tx_rst_n,
    input wire logic                  rx_rst_n,
    input wire logic                  csr_rst_n,
    input wire rst_stat_pkg::phy_in_t phy_in,
    input wire rst_stat_pkg::status_t status,
    input wire logic [3:0]            s_axi_wstrb,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic [13:0]           s_axi_araddr,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp,
    input wire logic                  s_axi_rvalid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ****************************************
    // Run of consecutive sync headers
    // ****************************************
    logic [7:0] hdr_run_q;
    logic [7:0] hdr_run_d;
    always_comb begin
        hdr_run_d = 8'h0;
        if (phy_in.sync_hdr_ok)
            hdr_run_d = (hdr_run_q == 8'hFF) ? 8'hFF : hdr_run_q + 8'h1;
    end
    always_ff @(posedge aclk) begin
        hdr_run_q <= aresetn ? hdr_run_d : 8'h0;
    end

    sequence s_hdr_gone; !phy_in.sync_hdr_ok [*5]; endsequence
    sequence s_csr_held; !csr_rst_n [*3]; endsequence
    sequence s_part_wr;
        s_axi_wvalid && s_axi_wready && s_axi_wstrb != 4'hF;
    endsequence
    sequence s_low_rd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[13:2] < PHY_LO_W;
    endsequence

    a_pcs_ready_lock: assert property (
        status.rx_block_lock |-> status.rx_pcs_ready)
        else $error("pcs ready low under block lock");
    a_marker_follow: assert property (
        !FEC_EN |-> status.receive_marker_locked == status.rx_block_lock)
        else $error("marker lock differs from block lock");
    a_lock_run_len: assert property (
        $rose(status.rx_block_lock) |-> $past(hdr_run_q, 3) >= 8'h40)
        else $error("block lock before 64 headers");
    a_lock_hdr_loss: assert property (
        s_hdr_gone |-> !status.rx_block_lock)
        else $error("block lock kept without headers");
    a_tx_rst_low: assert property (
        !tx_rst_n [*3] |-> !status.tx_lanes_stable)
        else $error("lanes stable under tx reset");
    a_rx_rst_low: assert property (
        !rx_rst_n [*3] |-> !status.rx_pcs_ready && !status.rx_block_lock)
        else $error("rx status high under rx reset");
    a_csr_rst_low: assert property (
        s_csr_held |-> !status.tx_lanes_stable && !status.rx_pcs_ready)
        else $error("ready high under global reset");
    a_lanes_need_ok: assert property (
        !phy_in.tx_lanes_ok [*5] |-> !status.tx_lanes_stable)
        else $error("lanes stable without lanes ok");
    a_fault_clear: assert property (
        (!phy_in.local_fault && !phy_in.remote_fault) [*5]
        |-> !status.local_fault_status && !status.remote_fault_status)
        else $error("fault status without fault");
    a_strb_slverr: assert property (
        s_part_wr |-> ##[0:4] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
        else $error("partial write not refused");
    a_unmapped_rd: assert property (
        s_low_rd |-> ##[0:3] (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
                              && s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
endmodule

// [sim/link_partner_model.sv]
// Purpose: Far-side controller driving hard resets and link state
// Assumes: One-cycle reset requests from the bench
// Notes:   Each hard reset held exactly ten cycles
`timescale 1ns/1ps
module link_partner_model
    import rst_stat_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic [2:0]            rst_req,
    input  wire rst_stat_pkg::phy_in_t link,
    output logic                       tx_rst_n,
    output logic                       rx_rst_n,
    output logic                       csr_rst_n,
    output rst_stat_pkg::phy_in_t      phy_in
);
    logic [3:0] hold_q [3] = '{default: 4'h0};

    always @(posedge aclk) begin
        for (int i = 0; i < 3; i++) begin
            if (rst_req[i])
                hold_q[i] <= 4'hA;
            else if (hold_q[i] != 4'h0)
                hold_q[i] <= hold_q[i] - 4'h1;
        end
        phy_in <= link;
    end
    assign tx_rst_n  = (hold_q[0] == 4'h0);
    assign rx_rst_n  = (hold_q[1] == 4'h0);
    assign csr_rst_n = (hold_q[2] == 4'h0);
endmodule

// [sim/eth_reset_status_ctrl_tb.sv]
// Purpose: Self-checking bench for the reset and status block
// Assumes: FEC off, fault generation and unidirectional support on
// Notes:   Scratch data and fault levels drawn from a fixed seed
`timescale 1ns/1ps
module eth_reset_status_ctrl_tb;
    import rst_stat_pkg::*;
    logic        aclk, aresetn, channel_reset, tx_rst_n, rx_rst_n, csr_rst_n;
    logic [2:0]  rst_req;
    phy_in_t     link;
    phy_in_t     phy_in;
    status_t     status;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          failures, compares, cyc, n, seed;
    logic [11:0] ofs [11] = '{12'h2FF, PHY_HI_W, TXMAC_LO_W, RXMAC_HI_W,
        FLOW_HI_W, 12'h709, 12'h7FF, STAT_HI_W, TSTAMP_LO_W, FEC_HI_W, 12'hE00};

    eth_reset_status_ctrl i_eth_reset_status_ctrl (
        .aclk, .aresetn, .tx_rst_n, .rx_rst_n, .csr_rst_n, .channel_reset,
        .phy_in, .status, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    link_partner_model i_link_partner_model (
        .aclk, .rst_req, .link, .tx_rst_n, .rx_rst_n, .csr_rst_n, .phy_in
    );

    // ****************************************
    // Expectations, checks and bus tasks
    // ****************************************
    function automatic logic [1:0] exp_resp(input logic [11:0] w);
        return ((w >= PHY_LO_W && w <= FLOW_HI_W) ||
                (w >= STAT_LO_W && w <= FEC_HI_W)) ? RESP_OKAY : RESP_SLVERR;
    endfunction
    function automatic status_t exp_status(input phy_in_t l);
        return {l.tx_lanes_ok, l.sync_hdr_ok, l.sync_hdr_ok, l.sync_hdr_ok,
                l.local_fault, l.remote_fault, 2'h3};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] w, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        s_axi_awaddr  <= {w, 2'h0};
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd_chk(input logic [11:0] w, input logic [31:0] ed,
                          input logic [1:0] er);
        s_axi_araddr  <= {w, 2'h0};
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic pulse_rst(input logic [2:0] m);
        rst_req <= m;
        @(posedge aclk);
        rst_req <= 3'h0;
        repeat (5) @(posedge aclk);
    endtask
    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************
    // Clock, timeout and main sequence
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        {failures, compares, cyc, n} = '0;
        seed = 32'hA57EF29F;
        {aresetn, channel_reset, rst_req, link} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // No calibration to disable before access
        @(posedge aclk);
        rd_chk(SCRATCH_W, SCRATCH_RST, RESP_OKAY);
        wr(REVISION_W, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd_chk(REVISION_W, REVISION_VAL, RESP_OKAY);
        foreach (ofs[i]) begin
            wr(ofs[i], 32'h5A5A5A5A, 4'hF, exp_resp(ofs[i]));
            rd_chk(ofs[i], 32'h0, exp_resp(ofs[i]));
        end
        repeat (6) begin
            rnd = $random(seed);
            wr(SCRATCH_W, rnd, 4'hF, RESP_OKAY);
            rd_chk(SCRATCH_W, rnd, RESP_OKAY);
        end
        wr(SCRATCH_W, ~rnd, {1'b0, rnd[2:0]}, RESP_SLVERR);
        rd_chk(SCRATCH_W, rnd, RESP_OKAY);
        pulse_rst(3'h3);
        rd_chk(SCRATCH_W, rnd, RESP_OKAY);
        pulse_rst(3'h4);
        repeat (10) @(posedge aclk);
        rd_chk(SCRATCH_W, SCRATCH_RST, RESP_OKAY);
        $display("register test done");
        link <= 5'h18;
        repeat (40) @(posedge aclk);
        link.sync_hdr_ok <= 1'b0;
        @(posedge aclk);
        link.sync_hdr_ok <= 1'b1;
        for (n = 0; n < 200 && status.rx_block_lock !== 1'b1; n++)
            @(posedge aclk);
        chk(32'(n >= 64 && n <= 80), 32'h1);
        chk(status, exp_status(link));
        rd_chk(STATUS_W, {24'h0, exp_status(link)}, RESP_OKAY);
        repeat (6) begin
            rnd = $random(seed);
            link <= {3'h6, rnd[1:0]};
            repeat (6) @(posedge aclk);
            chk(status, exp_status(link));
        end
        $display("status test done");
        for (int m = 1; m <= 4; m = m * 2) begin
            pulse_rst(3'(m));
            chk({status.tx_lanes_stable, status.rx_pcs_ready},
                {~m[0] & ~m[2], ~m[1] & ~m[2]});
            repeat (100) @(posedge aclk);
            chk(status, exp_status(link));
        end
        channel_reset <= 1'b1;
        repeat (5) @(posedge aclk);
        chk({status.tx_lanes_stable, status.rx_pcs_ready}, 32'h0);
        channel_reset <= 1'b0;
        repeat (100) @(posedge aclk);
        chk(status, exp_status(link));
        wr(CONTROL_W, 32'h3, 4'hF, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({status.tx_lanes_stable, status.rx_pcs_ready}, 32'h0);
        rd_chk(CONTROL_W, 32'h3, RESP_OKAY);
        wr(CONTROL_W, 32'h0, 4'hF, RESP_OKAY);
        repeat (100) @(posedge aclk);
        chk(status, exp_status(link));
        $display("reset test done");
        test_done();
    end
endmodule

bind eth_reset_status_ctrl eth_reset_status_ctrl_assertions #(
    .FEC_EN(FEC_EN)
) i_eth_reset_status_ctrl_assertions (
    .aclk, .aresetn, .tx_rst_n, .rx_rst_n, .csr_rst_n, .phy_in, .status,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid
);
